//--- dv/imu_config_command_regs_test.sv
/*
 Self-checking bench for the configuration and command registers.
 Assumes the host model drives the bus; the bench plays the command engine.
*/
`timescale 1ns/1ps
`default_nettype none
module imu_config_command_regs_test;
   // Identity value is arbitrary, not a real part code
   localparam logic [15:0] ID = 16'h5A5A;
   localparam logic [15:0] REV = 16'h0203;
   localparam logic [15:0] DM = 16'h0415;
   localparam logic [15:0] YR = 16'h2021;
   localparam logic [15:0] SN = 16'h0042;
   // Short timeout keeps the run brief
   localparam int CMDN = 40;
   logic clk, resetn, clk_en, rd_req, rd_ack, host_ready, engine_done, sample_tick;
   logic data_ready_pin, soft_reset, bias_offset_clear, apply_bias, rd_ok;
   logic clr_seen, app_seen, rst_seen;
   logic [6:0] rd_addr;
   logic [15:0] rd_data, diagnostic_status, sync_freq_hz, rd_val;
   logic [7:0] cmd_start, last_cmd;
   logic [31:0] sample_rate_num;
   logic [11:0] sample_rate_den;
   logic [5:0] axis_bias_enable;
   logic [3:0] time_base_exponent;
   logic [2:0] sync_function;
   logic [10:0] decimation_setting;
   imu_cfg_pkg::write_type host_wr;
   imu_cfg_pkg::result_type engine_result;
   int failures, checks_done;

   imu_config_command_regs #(.CMD_CYCLES(CMDN), .FW_REVISION(REV), .CONFIG_DAY_MONTH(DM),
      .CONFIG_YEAR(YR), .PRODUCT_IDENTITY(ID), .UNIT_SERIAL(SN)) i_imu_config_command_regs (
      .clk(clk), .resetn(resetn), .clk_en(clk_en), .host_wr(host_wr), .rd_req(rd_req),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_ack(rd_ack), .host_ready(host_ready),
      .engine_done(engine_done), .engine_result(engine_result), .cmd_start(cmd_start),
      .diagnostic_status(diagnostic_status), .soft_reset(soft_reset),
      .sample_tick(sample_tick), .sync_freq_hz(sync_freq_hz),
      .data_ready_pin(data_ready_pin), .sample_rate_num(sample_rate_num),
      .sample_rate_den(sample_rate_den), .axis_bias_enable(axis_bias_enable),
      .time_base_exponent(time_base_exponent), .sync_function(sync_function),
      .decimation_setting(decimation_setting), .bias_offset_clear(bias_offset_clear),
      .apply_bias(apply_bias));

   imu_host_model i_imu_host_model (.clk(clk), .host_wr(host_wr), .rd_req(rd_req),
      .rd_addr(rd_addr), .rd_data(rd_data), .rd_ack(rd_ack));

   // Pulses are caught here since they stand for one cycle only
   always @(posedge clk) begin
      if (cmd_start != 8'h00) last_cmd <= cmd_start;
      if (bias_offset_clear) clr_seen <= 1'b1;
      if (apply_bias) app_seen <= 1'b1;
      if (soft_reset) rst_seen <= 1'b1;
   end

   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      i_imu_host_model.wr_word(a, d);
   endtask

   task automatic rd(input logic [6:0] a, input logic k, input logic [15:0] e, input string n);
      i_imu_host_model.rd_word(a, rd_val, rd_ok);
      chk({n, " ack"}, 32'(k), 32'(rd_ok));
      if (k) chk(n, 32'(e), 32'(rd_val));
   endtask

   task automatic tick(input logic e);
      @(negedge clk);
      sample_tick = 1'b1;
      @(negedge clk);
      sample_tick = 1'b0;
      chk("data ready", 32'(e), 32'(data_ready_pin));
   endtask

   task automatic wait_ready(output int n);
      n = 0;
      while (host_ready !== 1'b1 && n < 200) begin
         @(negedge clk);
         n++;
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs;
      rd(7'h66, 1'b1, 16'h070A, "bias cfg");
      rd(7'h6D, 1'b1, REV, "revision");
      rd(7'h6E, 1'b1, DM, "day month");
      rd(7'h70, 1'b1, YR, "year");
      rd(7'h74, 1'b1, SN, "serial");
      wr(7'h72, 16'hFFFF);
      rd(7'h72, 1'b1, ID, "identity");
      rd(7'h7E, 1'b1, 16'h0000, "unmapped");
      wr(7'h76, 16'hBEEF);
      rd(7'h76, 1'b1, 16'hBEEF, "scratch");
      // A write while the enable is low must leave every register alone
      clk_en = 1'b0;
      wr(7'h76, 16'h1234);
      clk_en = 1'b1;
      rd(7'h76, 1'b1, 16'hBEEF, "frozen scratch");
      wr(7'h66, 16'hF50D);
      rd(7'h66, 1'b1, 16'h350C, "bias clip");
      chk("axis enable", 32'h35, 32'(axis_bias_enable));
      chk("time base", 32'hC, 32'(time_base_exponent));
      tick(1'b1);
   endtask

   task automatic t_rate;
      wr(7'h62, 16'h0003);
      wr(7'h64, 16'h0005);
      wr(7'h60, 16'h0008);
      chk("scaled num", 32'h12C, sample_rate_num);
      chk("den", 32'h6, 32'(sample_rate_den));
      wr(7'h60, 16'h0004);
      chk("direct num", 32'h64, sample_rate_num);
      wr(7'h60, 16'h0014);
      chk("pulse num", 32'h64, sample_rate_num);
      chk("sync fn", 32'h5, 32'(sync_function));
      wr(7'h64, 16'hFFFF);
      chk("dec cap", 32'h7CF, 32'(decimation_setting));
      chk("den cap", 32'h7D0, 32'(sample_rate_den));
   endtask

   task automatic t_cmds;
      int b[5] = '{4, 3, 2, 1, 0};
      logic [2:0] r[5] = '{3'h4, 3'h1, 3'h2, 3'h0, 3'h0};
      logic [15:0] dg[5] = '{16'h40, 16'h44, 16'h64, 16'h64, 16'h64};
      for (int i = 0; i < 5; i++) begin
         clr_seen = 1'b0;
         app_seen = 1'b0;
         wr(7'h68, 16'(1 << b[i]));
         chk("cmd", 32'(1 << b[i]), 32'(last_cmd));
         chk("ready busy", 32'h0, 32'(host_ready));
         rd(7'h66, 1'b0, 16'h0000, "busy read");
         tick(1'b0);
         engine_done = 1'b1;
         engine_result = r[i];
         @(negedge clk);
         engine_done = 1'b0;
         engine_result = ~r[i];
         chk("ready after", 32'h1, 32'(host_ready));
         chk("diag", 32'(dg[i]), 32'(diagnostic_status));
         chk("clear", 32'(b[i] == 1), 32'(clr_seen));
         chk("apply", 32'(b[i] == 0), 32'(app_seen));
      end
      chk("restore sync", 32'h0, 32'(sync_function));
      chk("restore dec", 32'h0, 32'(decimation_setting));
      tick(1'b1);
   endtask

   task automatic t_timeout;
      int n;
      wr(7'h68, 16'h0010);
      wait_ready(n);
      chk("timeout span", 32'h1, 32'(n >= CMDN - 4 && n <= CMDN + 2));
   endtask

   task automatic t_soft;
      int n;
      rst_seen = 1'b0;
      wr(7'h68, 16'h0080);
      chk("soft reset", 32'h1, 32'(rst_seen));
      wait_ready(n);
      rd(7'h76, 1'b1, 16'h0000, "scratch");
      rd(7'h66, 1'b1, 16'h070A, "bias cfg");
      chk("diag", 32'h0, 32'(diagnostic_status));
   endtask

   task automatic close_out;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ****************************************
   // Run
   // ****************************************
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      resetn = 1'b0;
      clk_en = 1'b1;
      engine_done = 1'b0;
      engine_result = '0;
      sample_tick = 1'b0;
      sync_freq_hz = 16'h0064;
      failures = 0;
      checks_done = 0;
      last_cmd = 8'h00;
      clr_seen = 1'b0;
      app_seen = 1'b0;
      rst_seen = 1'b0;
      repeat (5) @(negedge clk);
      resetn = 1'b1;
      t_regs();
      t_rate();
      t_cmds();
      t_timeout();
      t_soft();
      close_out();
   end

   // The whole run needs well under a thousand cycles
   initial begin
      #(20000 * 8);
      failures++;
      close_out();
   end
endmodule // imu_config_command_regs_test
`default_nettype wire

//--- dv/imu_host_model.sv
/*
 Host model: byte writes and word reads toward the register block.
 Assumes the bench clock; every change is made on the falling edge.
*/
`timescale 1ns/1ps
`default_nettype none
module imu_host_model (
   // Clock
   input wire logic clk,
   // Host side of the block
   output var imu_cfg_pkg::write_type host_wr,
   output logic rd_req,
   output logic [6:0] rd_addr,
   input wire logic [15:0] rd_data,
   input wire logic rd_ack
);
   initial begin
      host_wr = '0;
      rd_req = 1'b0;
      rd_addr = 7'h7F;
   end

   // ****************************************
   // Transfers
   // ****************************************
   // Low byte at the even address, high byte at the odd one
   task automatic wr_word(input logic [6:0] a, input logic [15:0] d);
      @(negedge clk);
      host_wr = {1'b1, a & 7'h7E, d[7:0]};
      @(negedge clk);
      host_wr = {1'b1, a | 7'h01, d[15:8]};
      @(negedge clk);
      // Released bus shows inverted data, so a stale byte cannot pass
      host_wr = {1'b0, ~a, ~d[15:8]};
   endtask

   task automatic rd_word(input logic [6:0] a, output logic [15:0] d, output logic ok);
      @(negedge clk);
      rd_req = 1'b1;
      rd_addr = a;
      @(negedge clk);
      rd_req = 1'b0;
      rd_addr = ~a;
      ok = rd_ack;
      d = rd_data;
   endtask
endmodule // imu_host_model
`default_nettype wire

//--- src/imu_cfg_pkg.sv
/*
 Constants, field layouts and carrier types for the inertial unit configuration and command
 register block. Assumes a host that writes through byte-wide write words and reads 16-bit
 registers by even byte address.
*/
// Contract
// R1: Scaled sync rate: sync times scale over decimation+1
// R2: Direct and pulse sync use unity scale
// R3: Bits 13..8 enable per-axis bias correction
// R4: Bits 3..0 hold time base exponent 0..12
// R5: Bias estimator config resets to 0x070A
// R6: Writing one to command bit starts function
// R7: Busy command stops data, ready pulses, host access
// R8: Command bit 7 performs software reset
// R9: Software reset equals external reset pin
// R10: Bit 4 CRC test, mismatch sets status 6
// R11: Bit 3 flash backup, status 2 reports failure
// R12: Bit 2 self test, result in status 5
// R13: Bit 1 restores factory settings, clears bias offsets
// R14: Bit 0 applies estimated bias corrections
// R15: Host sends low byte then zero high byte
// R16: Firmware revision read-only BCD
// R17: Day and month read-only BCD fields
// R18: Year read-only four-digit BCD
// R19: Product identity read-only fixed code
// R20: Sync field codes select five clock modes
// R21: Decimation eleven bits, capped at 1999
// R22: Register low byte even, high byte odd
// R23: Reject host until command done, then resume
`default_nettype none
package imu_cfg_pkg;

   // ****************************************************
   // Register map
   // ****************************************************
   localparam logic [6:0] MISC_CONTROL_ADDR = 7'h60;
   localparam logic [6:0] EXT_SCALE_ADDR = 7'h62;
   localparam logic [6:0] DECIMATION_ADDR = 7'h64;
   localparam logic [6:0] BIAS_CFG_ADDR = 7'h66;
   localparam logic [6:0] GLOBAL_CMD_ADDR = 7'h68;
   localparam logic [6:0] FW_REV_ADDR = 7'h6C;
   localparam logic [6:0] DAY_MONTH_ADDR = 7'h6E;
   localparam logic [6:0] YEAR_ADDR = 7'h70;
   localparam logic [6:0] PRODUCT_IDENTITY_ADDR = 7'h72;
   localparam logic [6:0] SERIAL_ADDR = 7'h74;
   localparam logic [6:0] SCRATCH_ADDR = 7'h76;

   // ****************************************************
   // Reset values and fields
   // ****************************************************
   localparam logic [15:0] BIAS_CFG_RESET = 16'h070A;
   localparam logic [15:0] BIAS_CFG_MASK = 16'h3F0F;
   localparam logic [15:0] MISC_CONTROL_RESET = 16'h00C1;
   localparam logic [15:0] MISC_CONTROL_MASK = 16'h00DF;
   localparam logic [15:0] EXT_SCALE_RESET = 16'h07D0;
   localparam logic [15:0] DECIMATION_RESET = 16'h0000;
   localparam logic [10:0] DECIMATION_MAX = 11'h7CF;
   localparam logic [3:0] TIME_BASE_MAX = 4'hC;
   localparam int AXIS_LSB = 8;
   localparam int NUM_AXES = 6;
   localparam int SYNC_LSB = 2;
   localparam int CMD_RESET_BIT = 7;
   localparam int CMD_CRC_BIT = 4;
   localparam int CMD_BACKUP_BIT = 3;
   localparam int CMD_SELFTEST_BIT = 2;
   localparam int CMD_RESTORE_BIT = 1;
   localparam int CMD_BIAS_BIT = 0;
   localparam int STAT_CRC_BIT = 6;
   localparam int STAT_SELFTEST_BIT = 5;
   localparam int STAT_BACKUP_BIT = 2;
   localparam logic [7:0] CMD_MASK = 8'h9F;

   // ****************************************************
   // Timing
   // ****************************************************
   localparam int CMD_TIME_US = 10;
   localparam int CLK_MHZ = 125;
   localparam int CMD_CYCLES = CMD_TIME_US * CLK_MHZ;

   typedef enum logic [2:0] {
      SYNC_INTERNAL = 3'h0,
      SYNC_DIRECT = 3'h1,
      SYNC_SCALED = 3'h2,
      SYNC_OUTPUT = 3'h3,
      SYNC_PULSE = 3'h5
   } sync_mode_type;

   typedef struct packed {
      logic valid;
      logic [6:0] addr;
      logic [7:0] data;
   } write_type;

   typedef struct packed {
      logic crc_fail;
      logic selftest_fail;
      logic backup_fail;
   } result_type;

endpackage
`default_nettype wire

//--- src/imu_config_command_regs.sv
/*
 Configuration and global command registers of the inertial unit. Assumes the serial front end
 delivers byte writes and 16-bit read requests synchronous to clk, and that the flash, self test
 and estimator engines report a done pulse and pass/fail results.
*/
`timescale 1ns/1ps
`default_nettype none
module imu_config_command_regs #(
   parameter int CMD_CYCLES = imu_cfg_pkg::CMD_CYCLES,
   parameter logic [15:0] FW_REVISION = 16'h0100,
   parameter logic [15:0] CONFIG_DAY_MONTH = 16'h0101,
   parameter logic [15:0] CONFIG_YEAR = 16'h2000,
   // Arbitrary identity value, not a real part code
   parameter logic [15:0] PRODUCT_IDENTITY = 16'h1234,
   parameter logic [15:0] UNIT_SERIAL = 16'h0001
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   input wire logic clk_en,
   // Host byte writes and word reads
   input wire imu_cfg_pkg::write_type host_wr,
   input wire logic rd_req,
   input wire logic [6:0] rd_addr,
   output logic [15:0] rd_data,
   output logic rd_ack,
   output logic host_ready,
   // Command engine
   input wire logic engine_done,
   input wire imu_cfg_pkg::result_type engine_result,
   output logic [7:0] cmd_start,
   output logic [15:0] diagnostic_status,
   output logic soft_reset,
   // Data path control
   input wire logic sample_tick,
   input wire logic [15:0] sync_freq_hz,
   output logic data_ready_pin,
   output logic [31:0] sample_rate_num,
   output logic [11:0] sample_rate_den,
   output logic [5:0] axis_bias_enable,
   output logic [3:0] time_base_exponent,
   output logic [2:0] sync_function,
   output logic [10:0] decimation_setting,
   output logic bias_offset_clear,
   output logic apply_bias
);

   // ****************************************************
   // Elaboration checks
   // ****************************************************
   // The busy counter cannot end a command that lasts no cycles
   if (CMD_CYCLES < 1) begin : g_bad_cycles
      $error("CMD_CYCLES must be at least one");
   end

   // ****************************************************
   // State
   // ****************************************************
   typedef enum {IDLE, BUSY} cmd_state_type;
   cmd_state_type state_reg, state_next;
   logic [31:0] count_reg;
   logic [7:0] lo_byte_reg;
   logic [15:0] bias_cfg_reg, misc_control_reg, ext_scale_reg, decimation_reg, scratch_reg;
   logic [7:0] pending_reg;
   logic [15:0] diag_reg;
   logic ready_reg;

   // ****************************************************
   // Write decode
   // ****************************************************
   // Low byte is staged; the word commits on the odd (high) byte write
   wire busy = (state_reg == BUSY);
   // Gating with clk_en keeps the command pulses frozen along with the state
   wire accept = clk_en && host_wr.valid && !busy; // [R7] [R23]
   wire odd = host_wr.addr[0]; // [R22]
   wire [6:0] base = {host_wr.addr[6:1], 1'b0};
   wire [15:0] word = {host_wr.data, lo_byte_reg}; // [R22]
   wire commit = accept && odd;
   wire wr_bias = commit && base == imu_cfg_pkg::BIAS_CFG_ADDR;
   wire wr_misc = commit && base == imu_cfg_pkg::MISC_CONTROL_ADDR;
   wire wr_scale = commit && base == imu_cfg_pkg::EXT_SCALE_ADDR;
   wire wr_dec = commit && base == imu_cfg_pkg::DECIMATION_ADDR;
   wire wr_scr = commit && base == imu_cfg_pkg::SCRATCH_ADDR;
   wire wr_cmd = commit && base == imu_cfg_pkg::GLOBAL_CMD_ADDR; // [R15]
   wire [7:0] cmd_bits = lo_byte_reg & imu_cfg_pkg::CMD_MASK;
   wire cmd_go = wr_cmd && cmd_bits != 8'h00; // [R6]
   // Exponents above 12 are clipped rather than stored
   wire [3:0] tb_in = (word[3:0] > imu_cfg_pkg::TIME_BASE_MAX) ?
      imu_cfg_pkg::TIME_BASE_MAX : word[3:0]; // [R4]
   wire [15:0] bias_in = {word[15:4], tb_in} & imu_cfg_pkg::BIAS_CFG_MASK; // [R3]
   wire [10:0] dec_in = (word[10:0] > imu_cfg_pkg::DECIMATION_MAX) ?
      imu_cfg_pkg::DECIMATION_MAX : word[10:0]; // [R21]
   // One qualified completion strobe for the restore and bias-apply pulses
   wire done_hit = clk_en && busy && engine_done;
   wire do_restore = done_hit && pending_reg[imu_cfg_pkg::CMD_RESTORE_BIT];
   wire sw_reset = cmd_go && cmd_bits[imu_cfg_pkg::CMD_RESET_BIT]; // [R8]

   // ****************************************************
   // Command sequencer
   // ****************************************************
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         IDLE: begin
            if (cmd_go) begin
               state_next = BUSY;
            end
         end
         BUSY: begin
            if (engine_done || count_reg == 32'(CMD_CYCLES - 1)) begin
               state_next = IDLE; // [R23]
            end
         end
         default: begin
            state_next = IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= IDLE;
         count_reg <= 32'h0;
         pending_reg <= 8'h00;
      end else if (clk_en) begin
         state_reg <= state_next;
         count_reg <= (state_next == BUSY && busy) ? count_reg + 32'h1 : 32'h0;
         if (cmd_go) begin
            pending_reg <= cmd_bits;
         end
      end
   end

   // ****************************************************
   // Registers
   // ****************************************************
   // Software reset reloads the same values as the pin reset
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lo_byte_reg <= 8'h00;
         bias_cfg_reg <= imu_cfg_pkg::BIAS_CFG_RESET; // [R5]
         misc_control_reg <= imu_cfg_pkg::MISC_CONTROL_RESET;
         ext_scale_reg <= imu_cfg_pkg::EXT_SCALE_RESET;
         decimation_reg <= imu_cfg_pkg::DECIMATION_RESET;
         scratch_reg <= 16'h0000;
      end else if (clk_en) begin
         if (sw_reset) begin
            bias_cfg_reg <= imu_cfg_pkg::BIAS_CFG_RESET; // [R9]
            misc_control_reg <= imu_cfg_pkg::MISC_CONTROL_RESET;
            ext_scale_reg <= imu_cfg_pkg::EXT_SCALE_RESET;
            decimation_reg <= imu_cfg_pkg::DECIMATION_RESET;
            scratch_reg <= 16'h0000;
            lo_byte_reg <= 8'h00;
         end else begin
            if (accept && !odd) begin
               lo_byte_reg <= host_wr.data;
            end
            if (wr_bias) begin
               bias_cfg_reg <= bias_in;
            end
            if (wr_scale) begin
               ext_scale_reg <= word;
            end
            if (wr_scr) begin
               scratch_reg <= word;
            end
            if (do_restore) begin
               misc_control_reg <= imu_cfg_pkg::MISC_CONTROL_RESET; // [R13]
               decimation_reg <= imu_cfg_pkg::DECIMATION_RESET;
            end else begin
               if (wr_misc) begin
                  misc_control_reg <= word & imu_cfg_pkg::MISC_CONTROL_MASK;
               end
               if (wr_dec) begin
                  decimation_reg <= {5'h00, dec_in};
               end
            end
         end
      end
   end

   // ****************************************************
   // Diagnostic results
   // ****************************************************
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         diag_reg <= 16'h0000;
      end else if (clk_en) begin
         if (sw_reset) begin
            diag_reg <= 16'h0000;
         end else if (busy && engine_done) begin
            if (pending_reg[imu_cfg_pkg::CMD_CRC_BIT]) begin
               diag_reg[imu_cfg_pkg::STAT_CRC_BIT] <= engine_result.crc_fail; // [R10]
            end
            if (pending_reg[imu_cfg_pkg::CMD_BACKUP_BIT]) begin
               diag_reg[imu_cfg_pkg::STAT_BACKUP_BIT] <= engine_result.backup_fail; // [R11]
            end
            if (pending_reg[imu_cfg_pkg::CMD_SELFTEST_BIT]) begin
               diag_reg[imu_cfg_pkg::STAT_SELFTEST_BIT] <=
                  engine_result.selftest_fail; // [R12]
            end
         end
      end
   end

   // ****************************************************
   // Read port
   // ****************************************************
   // Reads are refused while busy; the host sees no ack
   wire [6:0] rbase = {rd_addr[6:1], 1'b0};
   wire rd_take = rd_req && !busy; // [R7]
   wire [15:0] rd_word =
      (rbase == imu_cfg_pkg::BIAS_CFG_ADDR) ? bias_cfg_reg :
      (rbase == imu_cfg_pkg::MISC_CONTROL_ADDR) ? misc_control_reg :
      (rbase == imu_cfg_pkg::EXT_SCALE_ADDR) ? ext_scale_reg :
      (rbase == imu_cfg_pkg::DECIMATION_ADDR) ? decimation_reg :
      (rbase == imu_cfg_pkg::FW_REV_ADDR) ? FW_REVISION : // [R16]
      (rbase == imu_cfg_pkg::DAY_MONTH_ADDR) ? CONFIG_DAY_MONTH : // [R17]
      (rbase == imu_cfg_pkg::YEAR_ADDR) ? CONFIG_YEAR : // [R18]
      (rbase == imu_cfg_pkg::PRODUCT_IDENTITY_ADDR) ? PRODUCT_IDENTITY : // [R19]
      (rbase == imu_cfg_pkg::SERIAL_ADDR) ? UNIT_SERIAL :
      (rbase == imu_cfg_pkg::SCRATCH_ADDR) ? scratch_reg : 16'h0000;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rd_data <= 16'h0000;
         rd_ack <= 1'b0;
         ready_reg <= 1'b0;
      end else if (clk_en) begin
         rd_ack <= rd_take;
         if (rd_take) begin
            rd_data <= rd_word;
         end
         // Data ready pulses follow sample ticks only when idle
         ready_reg <= sample_tick && !busy && !cmd_go; // [R7]
      end
   end

   // ****************************************************
   // Outputs
   // ****************************************************
   wire [2:0] sync_sel = misc_control_reg[imu_cfg_pkg::SYNC_LSB +: 3]; // [R20]
   wire scaled = (sync_sel == imu_cfg_pkg::SYNC_SCALED);
   wire [15:0] scale_eff = scaled ? ext_scale_reg : 16'h0001; // [R1] [R2]
   assign sample_rate_num = 32'(sync_freq_hz) * 32'(scale_eff); // [R1]
   assign sample_rate_den = {1'b0, decimation_reg[10:0]} + 12'h001; // [R1]
   assign axis_bias_enable = bias_cfg_reg[imu_cfg_pkg::AXIS_LSB +: imu_cfg_pkg::NUM_AXES];
   assign time_base_exponent = bias_cfg_reg[3:0];
   assign sync_function = sync_sel;
   assign decimation_setting = decimation_reg[10:0];
   assign cmd_start = cmd_go ? cmd_bits : 8'h00; // [R6]
   assign soft_reset = sw_reset;
   assign bias_offset_clear = do_restore; // [R13]
   assign apply_bias = done_hit && pending_reg[imu_cfg_pkg::CMD_BIAS_BIT]; // [R14]
   assign diagnostic_status = diag_reg;
   assign data_ready_pin = ready_reg;
   assign host_ready = !busy; // [R23]

   // ****************************************************
   // Checks
   // ****************************************************
   sequence cmd_issue;
      clk_en && cmd_go && state_reg == IDLE;
   endsequence

   sequence engine_finish;
      clk_en && busy && engine_done;
   endsequence

   // Restore pulses the offset clear first, then shows the factory values
   sequence restore_steps;
      bias_offset_clear ##1 (misc_control_reg == imu_cfg_pkg::MISC_CONTROL_RESET &&
         decimation_reg == imu_cfg_pkg::DECIMATION_RESET);
   endsequence

   a_cmd_enters_busy: assert property (@(posedge clk) disable iff (!resetn) // [R6]
      cmd_issue |=> busy) else $error("command not started");
   a_cmd_bits_masked: assert property (@(posedge clk) disable iff (!resetn) // [R6]
      (cmd_start & ~imu_cfg_pkg::CMD_MASK) == 8'h00) else $error("unused command bit");
   a_busy_ends_done: assert property (@(posedge clk) disable iff (!resetn) // [R23]
      engine_finish |=> !busy) else $error("busy after done");
   // Counter view of the timeout, since the span is too long to unroll
   a_busy_bounded: assert property (@(posedge clk) disable iff (!resetn) // [R23]
      busy |-> count_reg < 32'(CMD_CYCLES)) else $error("command outlived its limit");
   // Reads need no wait state: the answer stands one cycle after the request
   a_read_answered: assert property (@(posedge clk) disable iff (!resetn) // [R23]
      clk_en && rd_req && !busy |=> rd_ack)
      else $error("read not answered");
   a_ready_follows_tick: assert property (@(posedge clk) disable iff (!resetn) // [R23]
      clk_en && sample_tick && !busy && !cmd_go |=> data_ready_pin)
      else $error("data ready missing");
   a_busy_blocks_ack: assert property (@(posedge clk) disable iff (!resetn) // [R7]
      busy |=> !rd_ack || $past(!busy)) else $error("ack while busy");
   a_ready_quiet_busy: assert property (@(posedge clk) disable iff (!resetn) // [R7]
      clk_en && busy |=> !data_ready_pin) else $error("data ready while busy");
   a_busy_drops_writes: assert property (@(posedge clk) disable iff (!resetn) // [R7]
      clk_en && busy |=> $stable(scratch_reg) && $stable(bias_cfg_reg))
      else $error("write taken while busy");
   a_soft_from_bit7: assert property (@(posedge clk) disable iff (!resetn) // [R8]
      soft_reset |-> cmd_start[imu_cfg_pkg::CMD_RESET_BIT]) else $error("stray soft reset");
   a_bias_cfg_reset: assert property (@(posedge clk) disable iff (!resetn) // [R5]
      clk_en && sw_reset |=> bias_cfg_reg == 16'h070A) else $error("bad reset");
   a_soft_reload: assert property (@(posedge clk) disable iff (!resetn) // [R9]
      clk_en && soft_reset |=> scratch_reg == 16'h0000 && diag_reg == 16'h0000 &&
         decimation_reg == imu_cfg_pkg::DECIMATION_RESET) else $error("soft reset incomplete");

   // ****************************************************
   // Checks: results and registers
   // ****************************************************
   a_crc_result: assert property (@(posedge clk) disable iff (!resetn) // [R10]
      engine_finish ##0 pending_reg[imu_cfg_pkg::CMD_CRC_BIT] |=>
         diagnostic_status[imu_cfg_pkg::STAT_CRC_BIT] == $past(engine_result.crc_fail))
      else $error("crc result not kept");
   a_backup_result: assert property (@(posedge clk) disable iff (!resetn) // [R11]
      engine_finish ##0 pending_reg[imu_cfg_pkg::CMD_BACKUP_BIT] |=>
         diagnostic_status[imu_cfg_pkg::STAT_BACKUP_BIT] == $past(engine_result.backup_fail))
      else $error("backup result not kept");
   a_selftest_result: assert property (@(posedge clk) disable iff (!resetn) // [R12]
      engine_finish ##0 pending_reg[imu_cfg_pkg::CMD_SELFTEST_BIT] |=>
         diagnostic_status[imu_cfg_pkg::STAT_SELFTEST_BIT] == $past(engine_result.selftest_fail))
      else $error("self test result not kept");
   a_restore_order: assert property (@(posedge clk) disable iff (!resetn) // [R13]
      engine_finish ##0 pending_reg[imu_cfg_pkg::CMD_RESTORE_BIT] |-> restore_steps)
      else $error("restore incomplete");
   a_bias_applied: assert property (@(posedge clk) disable iff (!resetn) // [R14]
      engine_finish ##0 pending_reg[imu_cfg_pkg::CMD_BIAS_BIT] |-> apply_bias)
      else $error("bias update missing");
   a_time_base_max: assert property (@(posedge clk) disable iff (!resetn) // [R4]
      time_base_exponent <= 4'hC) else $error("time base out of range");
   a_decim_capped: assert property (@(posedge clk) disable iff (!resetn) // [R21]
      decimation_setting <= 11'h7CF) else $error("decimation above cap");
   a_unity_scale: assert property (@(posedge clk) disable iff (!resetn) // [R2]
      !scaled |-> sample_rate_num == 32'(sync_freq_hz)) else $error("scale not unity");
   a_scaled_rate: assert property (@(posedge clk) disable iff (!resetn) // [R1]
      scaled |-> sample_rate_num == 32'(sync_freq_hz) * 32'(ext_scale_reg))
      else $error("scaled rate wrong");
   a_axis_unused_zero: assert property (@(posedge clk) disable iff (!resetn) // [R3]
      bias_cfg_reg[15:14] == 2'h0 && bias_cfg_reg[7:4] == 4'h0) else $error("bad bits");
   a_identity_read: assert property (@(posedge clk) disable iff (!resetn) // [R19]
      clk_en && rd_req && !busy && rbase == imu_cfg_pkg::PRODUCT_IDENTITY_ADDR |=>
         rd_ack && rd_data == PRODUCT_IDENTITY) else $error("identity read wrong");

endmodule // imu_config_command_regs
`default_nettype wire
